// *** jtag_tester.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// board tester model driving the scan pins
// ------------------------------
module jtag_tester
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  int stall_hi = 0; // extra ns with tck parked high
  // tck idles low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // one period; pins change with tck low, tdo taken just before the rise
  task automatic step(input logic m, input logic d, output logic q);
  begin
    tms = m;
    tdi = d;
    #80;
    q = tdo;
    tck = 1'b1;
    #(80 + stall_hi);
    tck = 1'b0;
  end
  endtask
  // five highs then idle, no trst needed
  task automatic tap_reset;
    logic q;
  begin
    repeat (5) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  end
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [280:0] din, output logic [280:0] dout);
    logic q;
  begin
    dout = '0;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
      step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tdi = ~tdi; // released line: no stale value
  end
  endtask
  // trst held long enough for the synchroniser to see it
  task automatic pulse_trst;
  begin
    trst_n = 1'b0;
    #100;
    trst_n = 1'b1;
    #100;
  end
  endtask
endmodule
`default_nettype wire

// *** tas_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// ------------------------------
// port checker: self-test, float mode, tap output timing
// ------------------------------
module tas_asserts #(
  parameter BIST_CYCLES = 295000,
  parameter N_OUT = 129
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_TCK,
  input wire logic O_TDO,
  input wire logic O_TDO_OE,
  input wire logic O_CORE_VOLTAGE_DETECT,
  input wire logic O_FLOAT_MODE,
  input wire logic O_FAULT_READY,
  input wire logic O_BIST_DONE,
  input wire logic [31:0] O_SELFTEST_RESULT,
  input wire logic O_FETCH_START,
  input wire logic [31:0] O_FETCH_ADDR,
  input wire logic [N_OUT-1:0] O_PAD_OE
);
  // cycles since reset release; saturates so a long idle never wraps
  logic [19:0] run_cnt_ff;
  always_ff @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
      run_cnt_ff <= 20'h0;
    else if (run_cnt_ff != 20'hFFFFF)
      run_cnt_ff <= run_cnt_ff + 20'h1;
  end
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  property p_detect_low;
    O_CORE_VOLTAGE_DETECT == 1'b0;
  endproperty
  a_detect_low: assert property (p_detect_low) else $error("detect output high");
  // pads and mode register on the same clock; the check still looks one cycle in
  property p_float_oe;
    O_FLOAT_MODE && $past(O_FLOAT_MODE) |-> O_PAD_OE == '0;
  endproperty
  a_float_oe: assert property (p_float_oe) else $error("pad driven in float mode");
  property p_float_hold;
    O_FLOAT_MODE |=> O_FLOAT_MODE;
  endproperty
  a_float_hold: assert property (p_float_hold) else $error("float mode left without reset");
  property p_fetch_addr;
    O_FETCH_START |-> O_BIST_DONE && O_FETCH_ADDR == 32'h0FFF_FFF0;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch start bad address");
  property p_fetch_pulse;
    $rose(O_BIST_DONE) |-> O_FETCH_START ##1 !O_FETCH_START;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch start not one pulse");
  property p_done_hold;
    O_BIST_DONE |=> O_BIST_DONE && $stable(O_SELFTEST_RESULT);
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("result moved after done");
  property p_bist_len;
    $rose(O_BIST_DONE) |-> run_cnt_ff >= BIST_CYCLES && run_cnt_ff <= BIST_CYCLES + 24;
  endproperty
  a_bist_len: assert property (p_bist_len) else $error("self-test length off");
  property p_no_fault_after;
    O_BIST_DONE |-> !O_FAULT_READY;
  endproperty
  a_no_fault_after: assert property (p_no_fault_after) else $error("faults taken after done");
  // tdo moves only after a falling tck, so tck is low when it moves
  property p_tdo_fall;
    $changed(O_TDO) |-> !I_TCK;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved with tck high");
  property p_tdo_oe_fall;
    $changed(O_TDO_OE) |-> !I_TCK;
  endproperty
  a_tdo_oe_fall: assert property (p_tdo_oe_fall) else $error("tdo enable moved with tck high");
endmodule
bind test_access_and_self_test tas_asserts #(.BIST_CYCLES(BIST_CYCLES), .N_OUT(N_OUT)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .I_TCK(I_TCK), .O_TDO(O_TDO), .O_TDO_OE(O_TDO_OE),
  .O_CORE_VOLTAGE_DETECT(O_CORE_VOLTAGE_DETECT), .O_FLOAT_MODE(O_FLOAT_MODE), .O_FAULT_READY(O_FAULT_READY),
  .O_BIST_DONE(O_BIST_DONE), .O_SELFTEST_RESULT(O_SELFTEST_RESULT), .O_FETCH_START(O_FETCH_START),
  .O_FETCH_ADDR(O_FETCH_ADDR), .O_PAD_OE(O_PAD_OE));
`default_nettype wire

// *** test_access_and_self_test.v ***
`timescale 1ns/10ps
`default_nettype none
`include "test_access_defs.vh"

// ----------------------------------------------------------------------------
// fault record fifo
// ----------------------------------------------------------------------------
module fault_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire i_clk,
  input wire i_reset_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage, no reset needed
  reg [AW:0] wr_ptr_ff; // extra bit tells full from empty
  reg [AW:0] rd_ptr_ff;
  wire full;
  wire empty;
  wire do_wr;
  wire do_rd;

  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign o_in_ready = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data = mem[rd_ptr_ff[AW-1:0]];
  assign do_wr = i_in_valid & ~full;
  assign do_rd = i_out_ready & ~empty;

  // write side
  always @(posedge i_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
    end
  end

  // pointers
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      wr_ptr_ff <= {(AW+1){1'b0}};
      rd_ptr_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_ff <= wr_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd)
      begin
        rd_ptr_ff <= rd_ptr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ----------------------------------------------------------------------------
// self-test, float test mode and boundary-scan port
// ----------------------------------------------------------------------------
module test_access_and_self_test #(
  parameter BIST_CYCLES = `BIST_CYCLES,
  parameter N_OUT = `BSR_OUT_CELLS,
  parameter N_IN = `BSR_IN_CELLS,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
)
(
  input wire I_REF_CLK,
  input wire I_RESET_N,
  input wire I_FLUSH_N,
  input wire I_TCK,
  input wire I_TMS,
  input wire I_TDI,
  input wire I_TRST_N,
  output reg O_TDO,
  output reg O_TDO_OE,
  output wire O_CORE_VOLTAGE_DETECT,
  output reg O_FLOAT_MODE,
  input wire I_FAULT_VALID,
  output wire O_FAULT_READY,
  input wire [31:0] I_FAULT_DATA,
  output wire O_LOG_VALID,
  input wire I_LOG_READY,
  output wire [31:0] O_LOG_DATA,
  output reg O_BIST_DONE,
  output reg [31:0] O_SELFTEST_RESULT,
  output reg O_FETCH_START,
  output reg [31:0] O_FETCH_ADDR,
  input wire [N_OUT-1:0] I_CORE_OUT,
  input wire [N_OUT-1:0] I_CORE_OE,
  input wire [N_OUT-1:0] I_PAD_IN,
  input wire [N_IN-1:0] I_IN_PIN,
  output reg [N_OUT-1:0] O_PAD_OUT,
  output reg [N_OUT-1:0] O_PAD_OE
);
  localparam BSR_N = 2 * N_OUT + N_IN + 1; // one reserved bit at position 0
  localparam [`BIST_CNT_W-1:0] BIST_LAST = BIST_CYCLES - 1;
  localparam B_RUN = 3'b001;
  localparam B_DRAIN = 3'b010;
  localparam B_DONE = 3'b100;

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  reg [4:0] sync1_ff; // {flush_n, trst_n, tdi, tms, tck}
  reg [4:0] sync2_ff; // only stage that logic reads
  reg tck_dly_ff; // previous synced tck for edge finding
  wire tck_s;
  wire tms_s;
  wire tdi_s;
  wire trst_n_s;
  wire flush_n_s;
  wire tck_rise;
  wire tck_fall;

  // two flops per pin; reset to the idle level of each pin
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      sync1_ff <= 5'h1E;
      sync2_ff <= 5'h1E;
      tck_dly_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= {I_FLUSH_N, I_TRST_N, I_TDI, I_TMS, I_TCK};
      sync2_ff <= sync1_ff;
      tck_dly_ff <= sync2_ff[0];
    end
  end

  assign tck_s = sync2_ff[0];
  assign tms_s = sync2_ff[1];
  assign tdi_s = sync2_ff[2];
  assign trst_n_s = sync2_ff[3];
  assign flush_n_s = sync2_ff[4];
  // a stopped tck makes no edges, so tap registers hold unless trst is low
  assign tck_rise = tck_s & ~tck_dly_ff;
  assign tck_fall = ~tck_s & tck_dly_ff;

  // pad readback and input pins cross in through two flops as well
  reg [N_OUT-1:0] pad_s1_ff;
  reg [N_OUT-1:0] pad_s2_ff; // only stage the capture reads
  reg [N_IN-1:0] pin_s1_ff;
  reg [N_IN-1:0] pin_s2_ff;

  // no reset: the capture image is only taken long after release
  always @(posedge I_REF_CLK)
  begin
    pad_s1_ff <= I_PAD_IN;
    pad_s2_ff <= pad_s1_ff;
    pin_s1_ff <= I_IN_PIN;
    pin_s2_ff <= pin_s1_ff;
  end

  // --------------------------------------------------------------------------
  // float test mode strap
  // --------------------------------------------------------------------------
  reg [1:0] strap_cnt_ff; // waits for the pin to clear the synchroniser
  reg float_ff; // float test mode active

  // catch the strap after release; async reset leaves the mode
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      strap_cnt_ff <= 2'h0;
      float_ff <= 1'b0;
    end
    else if (strap_cnt_ff != `STRAP_DELAY)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == `STRAP_DELAY - 2'h1)
      begin
        float_ff <= ~flush_n_s;
      end
    end
  end

  // detect pin is held low in every mode, including float
  assign O_CORE_VOLTAGE_DETECT = 1'b0;

  // --------------------------------------------------------------------------
  // built-in self-test sequencer
  // --------------------------------------------------------------------------
  reg [2:0] bist_state_ff; // one-hot
  reg [2:0] nxt_bist_state;
  reg [`BIST_CNT_W-1:0] bist_cnt_ff;
  reg [31:0] result_ff; // selftest_result_register
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire pop;

  // faults are only accepted while the engines run
  assign fifo_in_valid = I_FAULT_VALID & bist_state_ff[0];
  assign O_FAULT_READY = fifo_in_ready & bist_state_ff[0];
  assign pop = O_LOG_VALID & I_LOG_READY;

  fault_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fault_fifo (
    .i_clk(I_REF_CLK),
    .i_reset_n(I_RESET_N),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(I_FAULT_DATA),
    .o_out_valid(O_LOG_VALID),
    .i_out_ready(I_LOG_READY),
    .o_out_data(O_LOG_DATA)
  );

  // next state: run the full count, then drain logged faults
  always @*
  begin
    nxt_bist_state = bist_state_ff;
    case (bist_state_ff)
      B_RUN:
      begin
        if (bist_cnt_ff == BIST_LAST)
        begin
          nxt_bist_state = B_DRAIN;
        end
      end
      B_DRAIN:
      begin
        // a slow log consumer stretches this state, never skips it
        if (!O_LOG_VALID)
        begin
          nxt_bist_state = B_DONE;
        end
      end
      B_DONE:
      begin
        nxt_bist_state = B_DONE;
      end
      default:
      begin
        nxt_bist_state = B_RUN;
      end
    endcase
  end

  // every reset release restarts the test, there is no skip
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      bist_state_ff <= B_RUN;
      bist_cnt_ff <= {`BIST_CNT_W{1'b0}};
      result_ff <= `BIST_PASS_VALUE;
      O_BIST_DONE <= 1'b0;
      O_SELFTEST_RESULT <= `BIST_PASS_VALUE;
      O_FETCH_START <= 1'b0;
      O_FETCH_ADDR <= 32'h0000_0000;
    end
    else
    begin
      bist_state_ff <= nxt_bist_state;
      if (bist_state_ff == B_RUN)
      begin
        bist_cnt_ff <= bist_cnt_ff + {{(`BIST_CNT_W-1){1'b0}}, 1'b1};
      end
      if (pop)
      begin
        result_ff <= result_ff | O_LOG_DATA; // any fault bit leaves it nonzero
      end
      O_FETCH_START <= 1'b0;
      if (bist_state_ff == B_DRAIN && nxt_bist_state == B_DONE)
      begin
        O_BIST_DONE <= 1'b1;
        O_SELFTEST_RESULT <= result_ff;
        O_FETCH_START <= 1'b1; // pass or fail alike
        O_FETCH_ADDR <= `RESET_VECTOR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // tap controller
  // --------------------------------------------------------------------------
  reg [15:0] tap_ff; // one-hot state
  reg [15:0] nxt_tap;

  // standard sixteen-state graph
  always @*
  begin
    nxt_tap = tap_ff;
    case (tap_ff)
      `TAP_TLR: nxt_tap = tms_s ? `TAP_TLR : `TAP_RTI;
      `TAP_RTI: nxt_tap = tms_s ? `TAP_SEL_DR : `TAP_RTI;
      `TAP_SEL_DR: nxt_tap = tms_s ? `TAP_SEL_IR : `TAP_CAP_DR;
      `TAP_CAP_DR: nxt_tap = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_SHIFT_DR: nxt_tap = tms_s ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
      `TAP_EXIT1_DR: nxt_tap = tms_s ? `TAP_UPD_DR : `TAP_PAUSE_DR;
      `TAP_PAUSE_DR: nxt_tap = tms_s ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
      `TAP_EXIT2_DR: nxt_tap = tms_s ? `TAP_UPD_DR : `TAP_SHIFT_DR;
      `TAP_UPD_DR: nxt_tap = tms_s ? `TAP_SEL_DR : `TAP_RTI;
      `TAP_SEL_IR: nxt_tap = tms_s ? `TAP_TLR : `TAP_CAP_IR; // fifth high lands in reset
      `TAP_CAP_IR: nxt_tap = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_SHIFT_IR: nxt_tap = tms_s ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
      `TAP_EXIT1_IR: nxt_tap = tms_s ? `TAP_UPD_IR : `TAP_PAUSE_IR;
      `TAP_PAUSE_IR: nxt_tap = tms_s ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
      `TAP_EXIT2_IR: nxt_tap = tms_s ? `TAP_UPD_IR : `TAP_SHIFT_IR;
      `TAP_UPD_IR: nxt_tap = tms_s ? `TAP_SEL_DR : `TAP_RTI;
      default: nxt_tap = `TAP_TLR;
    endcase
  end

  // trst wins over any edge, three clocks after the pin (two synchroniser flops, then the state)
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      tap_ff <= `TAP_TLR;
    end
    else if (!trst_n_s)
    begin
      tap_ff <= `TAP_TLR;
    end
    else if (tck_rise)
    begin
      tap_ff <= nxt_tap;
    end
  end

  // --------------------------------------------------------------------------
  // instruction and data registers
  // --------------------------------------------------------------------------
  reg [`IR_W-1:0] ir_sh_ff; // shift stage, no parity bit
  reg [`IR_W-1:0] ir_up_ff; // active instruction
  reg [BSR_N-1:0] bsr_sh_ff;
  reg [BSR_N-1:0] bsr_up_ff;
  reg [31:0] id_sh_ff;
  reg bypass_ff;
  wire [BSR_N-1:0] bsr_cap;
  wire [31:0] id_value;
  wire sel_bsr;
  wire sel_id;
  wire is_extest;

  // three data registers chosen by the active instruction
  assign is_extest = (ir_up_ff == `IR_EXTEST);
  assign sel_bsr = is_extest | (ir_up_ff == `IR_SAMPLE);
  assign sel_id = (ir_up_ff == `IR_IDCODE);
  assign id_value = {`ID_VERSION, `ID_PART, `ID_MAKER, `ID_LSB};

  // capture image: value and enable per output cell, one bit per input
  assign bsr_cap[0] = 1'b0; // reserved cell, no pin
  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi = gi + 1)
    begin : g_out_cell
      // sample sees an enabled bidir as output; extest always as input
      assign bsr_cap[2*gi+1] = (!is_extest && I_CORE_OE[gi]) ? I_CORE_OUT[gi] : pad_s2_ff[gi];
      assign bsr_cap[2*gi+2] = I_CORE_OE[gi];
      // pins: core or extest image, float mode overrides
      always @(posedge I_REF_CLK or negedge I_RESET_N)
      begin
        if (!I_RESET_N)
        begin
          O_PAD_OUT[gi] <= 1'b0;
          O_PAD_OE[gi] <= 1'b0;
        end
        else if (is_extest)
        begin
          O_PAD_OUT[gi] <= bsr_up_ff[2*gi+1];
          O_PAD_OE[gi] <= bsr_up_ff[2*gi+2] & ~float_ff; // zero floats, one drives
        end
        else
        begin
          O_PAD_OUT[gi] <= I_CORE_OUT[gi];
          O_PAD_OE[gi] <= I_CORE_OE[gi] & ~float_ff;
        end
      end
    end
    for (gi = 0; gi < N_IN; gi = gi + 1)
    begin : g_in_cell
      assign bsr_cap[2*N_OUT+1+gi] = pin_s2_ff[gi];
    end
  endgenerate

  // capture, shift and update stages, all on the sampled tck rise
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ir_sh_ff <= `IR_CAPTURE;
      ir_up_ff <= `IR_IDCODE;
      bsr_sh_ff <= {BSR_N{1'b0}};
      bsr_up_ff <= {BSR_N{1'b0}};
      id_sh_ff <= 32'h0000_0000;
      bypass_ff <= 1'b0;
    end
    else if (tap_ff == `TAP_TLR)
    begin
      ir_up_ff <= `IR_IDCODE; // reset state selects identification
    end
    else if (tck_rise)
    begin
      case (tap_ff)
        `TAP_CAP_IR: ir_sh_ff <= `IR_CAPTURE;
        `TAP_SHIFT_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`IR_W-1:1]};
        `TAP_UPD_IR: ir_up_ff <= ir_sh_ff;
        `TAP_CAP_DR:
        begin
          if (sel_bsr)
          begin
            bsr_sh_ff <= bsr_cap;
          end
          id_sh_ff <= id_value;
          bypass_ff <= 1'b0;
        end
        `TAP_SHIFT_DR:
        begin
          if (sel_bsr)
          begin
            bsr_sh_ff <= {tdi_s, bsr_sh_ff[BSR_N-1:1]}; // tdi into top bit
          end
          else if (sel_id)
          begin
            id_sh_ff <= {tdi_s, id_sh_ff[31:1]};
          end
          else
          begin
            bypass_ff <= tdi_s;
          end
        end
        `TAP_UPD_DR:
        begin
          if (sel_bsr)
          begin
            bsr_up_ff <= bsr_sh_ff;
          end
        end
        default:
        begin
          bypass_ff <= bypass_ff;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // test data output, changed only on the falling tck; trst also clears the enable
  // --------------------------------------------------------------------------
  // tdo keeps working in float mode so the port stays usable
  always @(posedge I_REF_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_TDO <= 1'b0;
      O_TDO_OE <= 1'b0;
      O_FLOAT_MODE <= 1'b0;
    end
    else
    begin
      O_FLOAT_MODE <= float_ff;
      if (!trst_n_s)
      begin
        O_TDO_OE <= 1'b0;
      end
      else if (tck_fall)
      begin
        O_TDO_OE <= (tap_ff == `TAP_SHIFT_IR) | (tap_ff == `TAP_SHIFT_DR);
        if (tap_ff == `TAP_SHIFT_IR)
        begin
          O_TDO <= ir_sh_ff[0];
        end
        else if (sel_bsr)
        begin
          O_TDO <= bsr_sh_ff[0]; // bit 0 leaves first
        end
        else if (sel_id)
        begin
          O_TDO <= id_sh_ff[0];
        end
        else
        begin
          O_TDO <= bypass_ff;
        end
      end
    end
  end
endmodule

`default_nettype wire

// *** test_access_and_self_test_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "test_access_defs.vh"
module test_access_and_self_test_tb;
  localparam int BC = 50; // short self-test for simulation
  logic clk, rst_n, flush_n, fault_valid, log_ready;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, detect, float_mode, fault_ready, log_valid, bist_done, fetch_start;
  logic [31:0] fault_data, log_data, result, fetch_addr;
  logic [128:0] core_out, core_oe, pad_in, pad_out, pad_oe;
  logic [21:0] in_pin;
  logic [280:0] dout;
  int failures = 0;
  int check_count = 0;
  // ------------------------------
  // clock, device, tester
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  test_access_and_self_test #(.BIST_CYCLES(BC)) u_dut (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_FLUSH_N(flush_n), .I_TCK(tck), .I_TMS(tms), .I_TDI(tdi),
    .I_TRST_N(trst_n), .O_TDO(tdo), .O_TDO_OE(tdo_oe), .O_CORE_VOLTAGE_DETECT(detect), .O_FLOAT_MODE(float_mode),
    .I_FAULT_VALID(fault_valid), .O_FAULT_READY(fault_ready), .I_FAULT_DATA(fault_data), .O_LOG_VALID(log_valid),
    .I_LOG_READY(log_ready), .O_LOG_DATA(log_data), .O_BIST_DONE(bist_done), .O_SELFTEST_RESULT(result),
    .O_FETCH_START(fetch_start), .O_FETCH_ADDR(fetch_addr), .I_CORE_OUT(core_out), .I_CORE_OE(core_oe),
    .I_PAD_IN(pad_in), .I_IN_PIN(in_pin), .O_PAD_OUT(pad_out), .O_PAD_OE(pad_oe));
  jtag_tester u_tester (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic chk(input logic [280:0] a, input logic [280:0] e);
  begin
    check_count++;
    if (a !== e)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  end
  endtask
  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // eight clocks of reset with the strap level given
  task automatic do_reset(input logic f);
  begin
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    flush_n = f;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
  end
  endtask
  // fetch pulse stands one cycle, so look inside every cycle; bounded
  task automatic wait_fetch(output int k);
  begin
    k = 0;
    while (fetch_start !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      #2;
      k++;
    end
    chk(fetch_start, 1'b1);
  end
  endtask
  // expected capture: sample sees driven value when enabled, extest sees the pad
  function automatic logic [280:0] bsr_exp(input bit ext);
    logic [280:0] e;
  begin
    e = '0; // reserved cell reads zero
    for (int k = 0; k < 129; k++)
    begin
      e[2*k+1] = (core_oe[k] && !ext) ? core_out[k] : pad_in[k];
      e[2*k+2] = core_oe[k];
    end
    for (int j = 0; j < 22; j++)
      e[259+j] = in_pin[j];
    return e;
  end
  endfunction
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_bist_pass;
    int k;
  begin
    do_reset(1'b1);
    wait_fetch(k);
    chk(k, BC + 1);
    chk(result, `BIST_PASS_VALUE);
    chk(fetch_addr, 32'h0FFF_FFF0);
    chk(bist_done, 1'b1);
    $display("self-test pass case done");
  end
  endtask
  // fill the fault buffer until it refuses, drain stalled, then collect the or
  task automatic t_bist_fail;
    int acc, k;
    logic rdy;
  begin
    do_reset(1'b1);
    log_ready = 1'b0;
    acc = 0;
    repeat (20)
    begin
      fault_valid = 1'b1;
      fault_data = 32'h1 << acc;
      #6;
      rdy = fault_ready;
      @(posedge clk);
      #1;
      if (rdy)
        acc++;
    end
    fault_valid = 1'b0;
    chk(acc, 16);
    chk(fault_ready, 1'b0);
    chk(log_data, 32'h0000_0001);
    log_ready = 1'b1;
    wait_fetch(k);
    chk(result, 32'h0000_FFFF);
    chk(fetch_addr, 32'h0FFF_FFF0);
    chk(log_valid, 1'b0);
    $display("self-test fail case done");
  end
  endtask
  task automatic t_float;
  begin
    do_reset(1'b0);
    repeat (6) @(posedge clk);
    #1;
    flush_n = 1'b1;
    chk(float_mode, 1'b1);
    chk(pad_oe, 129'h0);
    chk(detect, 1'b0);
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(float_mode, 1'b0);
    do_reset(1'b1);
    repeat (6) @(posedge clk);
    #1;
    chk(float_mode, 1'b0);
    $display("float mode case done");
  end
  endtask
  // ten ir bits: captured 00001 first, then our own five; idcode left active
  task automatic t_ir_id;
  begin
    u_tester.tap_reset;
    u_tester.scan(1'b1, 10, {5'h02, 5'h16}, dout);
    chk(dout[9:0], {5'h16, 5'h01});
    u_tester.stall_hi = 400;
    u_tester.scan(1'b0, 32, 281'h0, dout);
    u_tester.stall_hi = 0;
    chk(dout[31:0], {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    $display("instruction and id case done");
  end
  endtask
  task automatic t_bypass_trst;
  begin
    u_tester.scan(1'b1, 5, 281'h1F, dout);
    u_tester.scan(1'b0, 9, 281'hB4, dout);
    chk(dout[8:0], {8'hB4, 1'b0});
    u_tester.tap_reset;
    u_tester.scan(1'b0, 32, 281'h0, dout);
    chk(dout[31:0], {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    u_tester.scan(1'b1, 5, 281'h1F, dout);
    u_tester.pulse_trst;
    u_tester.scan(1'b0, 32, 281'h0, dout);
    chk(dout[31:0], {`ID_VERSION, `ID_PART, `ID_MAKER, 1'b1});
    $display("bypass and trst case done");
  end
  endtask
  task automatic t_bsr;
    logic [280:0] v;
    logic [128:0] eo, ee;
  begin
    u_tester.scan(1'b1, 5, 281'h01, dout);
    u_tester.scan(1'b0, 281, 281'h0, dout);
    chk(dout, bsr_exp(1'b0));
    v = '0;
    for (int k = 0; k < 129; k++)
    begin
      v[2*k+1] = k[0];
      v[2*k+2] = (k % 3 == 0);
      eo[k] = k[0];
      ee[k] = (k % 3 == 0);
    end
    u_tester.scan(1'b1, 5, 281'h00, dout);
    fork
      u_tester.scan(1'b0, 281, v, dout);
      begin
        #20000;
        chk(tdo_oe, 1'b1);
      end
    join
    chk(dout, bsr_exp(1'b1));
    chk(pad_out, eo);
    chk(pad_oe, ee);
    $display("boundary register case done");
  end
  endtask
  // ------------------------------
  // main sequence and watchdog
  // ------------------------------
  initial
  begin
    rst_n = 1'b0;
    flush_n = 1'b1;
    fault_valid = 1'b0;
    fault_data = 32'h0;
    log_ready = 1'b1;
    core_out = {43{3'h3}};
    core_oe = {43{3'h5}};
    pad_in = {43{3'h6}};
    in_pin = 22'h25A5A5;
    t_bist_pass;
    t_bist_fail;
    t_float;
    t_ir_id;
    t_bypass_trst;
    t_bsr;
    test_done;
  end
  initial
  begin
    #400000;
    failures++;
    $display("watchdog expired");
    test_done;
  end
endmodule
`default_nettype wire

// *** test_access_defs.vh ***
`ifndef TEST_ACCESS_DEFS_VH
`define TEST_ACCESS_DEFS_VH

// ----------------------------------------------------------------------------
// self-test timing and result
// ----------------------------------------------------------------------------
`define BIST_CYCLES 295000
`define BIST_CNT_W 19
`define BIST_PASS_VALUE 32'h0000_0000
`define RESET_VECTOR 32'h0FFF_FFF0
`define STRAP_DELAY 2'h3

// ----------------------------------------------------------------------------
// tap controller states, one-hot
// ----------------------------------------------------------------------------
`define TAP_TLR 16'h0001
`define TAP_RTI 16'h0002
`define TAP_SEL_DR 16'h0004
`define TAP_CAP_DR 16'h0008
`define TAP_SHIFT_DR 16'h0010
`define TAP_EXIT1_DR 16'h0020
`define TAP_PAUSE_DR 16'h0040
`define TAP_EXIT2_DR 16'h0080
`define TAP_UPD_DR 16'h0100
`define TAP_SEL_IR 16'h0200
`define TAP_CAP_IR 16'h0400
`define TAP_SHIFT_IR 16'h0800
`define TAP_EXIT1_IR 16'h1000
`define TAP_PAUSE_IR 16'h2000
`define TAP_EXIT2_IR 16'h4000
`define TAP_UPD_IR 16'h8000

// ----------------------------------------------------------------------------
// instruction register
// ----------------------------------------------------------------------------
`define IR_W 5
`define IR_CAPTURE 5'h01
`define IR_EXTEST 5'h00
`define IR_SAMPLE 5'h01
`define IR_IDCODE 5'h02
`define IR_BYPASS 5'h1F

// ----------------------------------------------------------------------------
// boundary register layout
// ----------------------------------------------------------------------------
`define BSR_LEN 281
`define BSR_MSB 280
`define BSR_OUT_CELLS 129
`define BSR_IN_CELLS 22

// ----------------------------------------------------------------------------
// identification register; version, part and maker values are arbitrary
// ----------------------------------------------------------------------------
`define ID_VERSION 4'h0
`define ID_PART 16'h1234
`define ID_MAKER 11'h2AA
`define ID_LSB 1'h1

`endif
